// file: inc/icc_params.svh
`ifndef ICC_PARAMS_SVH
`define ICC_PARAMS_SVH
`define ICC_ADDR_CTRL 4'h0
`define ICC_ADDR_BUF 4'h1
`define ICC_ADDR_CNT 4'h2
`define ICC_BIT_IDLE 13
`define ICC_TSEL_HI 12
`define ICC_TSEL_LO 10
`define ICC_CPI_HI 6
`define ICC_CPI_LO 5
`define ICC_BIT_OV 4
`define ICC_BIT_BNE 3
`define ICC_MODE_HI 2
`define ICC_MODE_LO 0
`define ICC_WR_MASK 16'h3C67
`define ICC_CTRL_RST 16'h0000
`define ICC_PRE4 5'h04
`define ICC_PRE16 5'h10
`endif

// file: inc/icc_pkg.sv
package icc_pkg;
    typedef enum logic [2:0] {
        ICC_OFF = 3'h0, ICC_EVERY = 3'h1, ICC_RSV2 = 3'h2, ICC_FALL = 3'h3,
        ICC_PRE4 = 3'h4, ICC_PRE16 = 3'h5, ICC_UNUSED = 3'h6, ICC_WAKE = 3'h7
    } icc_mode_t;
    typedef enum logic [2:0] {
        ICC_T3 = 3'h0, ICC_T2 = 3'h1, ICC_T4 = 3'h2, ICC_T5 = 3'h3,
        ICC_T1 = 3'h4, ICC_RS5 = 3'h5, ICC_RS6 = 3'h6, ICC_FP = 3'h7
    } icc_tsel_t;
endpackage : icc_pkg

// file: hdl/icc_sync.sv
`timescale 1ns/10ps
module icc_sync (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // level
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } icc_sync_t;
    icc_sync_t st_ff;
    icc_sync_t nxt_st;
    always_comb begin
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign dout = st_ff.s2;
endmodule : icc_sync

// file: hdl/icc_fifo.sv
`timescale 1ns/10ps
module icc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // write side
    input wire logic push,
    input wire logic [WIDTH-1:0] wdata,
    // read side
    input wire logic pop,
    output logic [WIDTH-1:0] rdata,
    // status
    output logic nonempty,
    output logic full,
    // flush
    input wire logic flush
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } icc_fifo_t;
    icc_fifo_t st_ff;
    icc_fifo_t nxt_st;
    logic do_push;
    logic do_pop;
    always_comb begin
        nxt_st = st_ff;
        // a push into a full buffer is dropped; caller flags overflow
        do_push = push && (st_ff.cnt != (AW+1)'(DEPTH));
        do_pop = pop && (st_ff.cnt != '0);
        if (do_push) begin
            nxt_st.mem[st_ff.wp] = wdata;
            nxt_st.wp = st_ff.wp + 1'b1;
        end
        if (do_pop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        if (do_push && !do_pop) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end else if (do_pop && !do_push) begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
        if (flush) begin
            nxt_st.wp = '0;
            nxt_st.rp = '0;
            nxt_st.cnt = '0;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign rdata = st_ff.mem[st_ff.rp];
    assign nonempty = st_ff.cnt != '0;
    assign full = st_ff.cnt == (AW+1)'(DEPTH);
endmodule : icc_fifo

// file: hdl/icc_top.sv
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "icc_params.svh"
// Summary of operation
// [R1] idle halt bit stops channel in idle
// [R2] select 111 uses peripheral clock; 110/101 reserved
// [R3] select 100 uses timer one clock
// [R4] 011 t5, 010 t4, 001 t2, 000 t3
// [R5] interrupt every 2nd, 3rd, 4th capture
// [R6] count field ignored in modes 001, 111
// [R7] overflow flag set on buffer overflow
// [R8] nonempty bit shows unread captures
// [R9] mode 111: rising-edge wake interrupt only
// [R10] modes 110 and 000 disable channel
// [R11] prescale modes: every 4th/16th rise
// [R12] mode 011 captures every falling edge
// [R13] mode 001 captures both edges
// [R14] unimplemented bits ignore writes, read zero
// [R15] capture stores selected timebase count
// [R16] control fields reset to zero
module icc_top
    import icc_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int BUF_DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // capture pin and power state
    input wire logic capture_channel,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    // timebase counts, same clock domain
    input wire logic [CNT_W-1:0] timer_one_count,
    input wire logic [CNT_W-1:0] timer_two_count,
    input wire logic [CNT_W-1:0] timer_three_count,
    input wire logic [CNT_W-1:0] timer_four_count,
    input wire logic [CNT_W-1:0] timer_five_count,
    // event outputs
    output logic capture_irq,
    output logic capture_event
);
    typedef struct packed {
        logic idle_halt_select;
        icc_tsel_t capture_timebase_select;
        logic [1:0] captures_per_irq;
        logic capture_overflow_flag;
        icc_mode_t capture_mode_select;
        logic pin_d;
        logic [4:0] pre_cnt;
        logic [1:0] irq_cnt;
        logic [CNT_W-1:0] fp_cnt;
        logic irq;
        logic evt;
        logic [15:0] rdata;
    } icc_state_t;

    icc_state_t st_ff;
    icc_state_t nxt_st;
    logic pin_s;
    logic rise;
    logic fall;
    logic active;
    logic edge_hit;
    logic take;
    logic [CNT_W-1:0] tb_val;
    logic fifo_pop;
    logic [CNT_W-1:0] fifo_rdata;
    logic fifo_ne;
    logic fifo_full;
    logic fifo_flush;
    logic [4:0] pre_lim;
    logic [1:0] irq_lim;
    logic [15:0] ctrl_rd;

    icc_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din(capture_channel),
        .dout(pin_s)
    );

    icc_fifo #(
        .WIDTH(CNT_W),
        .DEPTH(BUF_DEPTH)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .push(take),
        .wdata(tb_val),
        .pop(fifo_pop),
        .rdata(fifo_rdata),
        .nonempty(fifo_ne),
        .full(fifo_full),
        .flush(fifo_flush)
    );

    assign rise = pin_s && !st_ff.pin_d;
    assign fall = !pin_s && st_ff.pin_d;

    // timebase mux; reserved codes fall back to the peripheral count
    always_comb begin
        unique case (st_ff.capture_timebase_select)
            ICC_FP: tb_val = st_ff.fp_cnt; // see [R2]
            ICC_T1: tb_val = timer_one_count; // see [R3]
            ICC_T5: tb_val = timer_five_count; // see [R4]
            ICC_T4: tb_val = timer_four_count; // see [R4]
            ICC_T2: tb_val = timer_two_count; // see [R4]
            ICC_T3: tb_val = timer_three_count; // see [R4]
            default: tb_val = st_ff.fp_cnt;
        endcase
    end

    // channel runs unless halted by idle; the wake mode only in sleep/idle
    always_comb begin
        active = !(st_ff.idle_halt_select && cpu_idle); // see [R1]
        edge_hit = 1'b0;
        pre_lim = `ICC_PRE4;
        unique case (st_ff.capture_mode_select)
            ICC_EVERY: edge_hit = rise || fall; // see [R13]
            ICC_FALL: edge_hit = fall; // see [R12]
            ICC_PRE4: edge_hit = rise; // see [R11]
            ICC_PRE16: begin
                edge_hit = rise; // see [R11]
                pre_lim = `ICC_PRE16;
            end
            ICC_WAKE: begin
                // halt bit is not applicable here
                active = cpu_sleep || cpu_idle; // see [R9]
                edge_hit = rise;
            end
            default: edge_hit = 1'b0; // see [R10]
        endcase
    end

    assign irq_lim = st_ff.captures_per_irq;
    assign fifo_pop = reg_rd && (reg_addr == `ICC_ADDR_BUF) && fifo_ne;
    assign fifo_flush = st_ff.capture_mode_select == ICC_OFF; // see [R10]

    always_comb begin
        nxt_st = st_ff;
        take = 1'b0;
        nxt_st.pin_d = pin_s;
        nxt_st.irq = 1'b0;
        nxt_st.evt = 1'b0;
        nxt_st.fp_cnt = st_ff.fp_cnt + 1'b1;
        if (active && edge_hit) begin
            if (st_ff.capture_mode_select == ICC_WAKE) begin
                nxt_st.irq = 1'b1; // see [R9]
            end else if (st_ff.capture_mode_select == ICC_PRE4 ||
                         st_ff.capture_mode_select == ICC_PRE16) begin
                if (st_ff.pre_cnt == pre_lim - 5'h01) begin
                    nxt_st.pre_cnt = '0;
                    take = 1'b1; // see [R11]
                end else begin
                    nxt_st.pre_cnt = st_ff.pre_cnt + 5'h01;
                end
            end else begin
                take = 1'b1;
            end
        end
        if (take) begin
            nxt_st.evt = 1'b1; // see [R15]
            if (fifo_full) begin
                nxt_st.capture_overflow_flag = 1'b1; // see [R7]
            end
            if (st_ff.capture_mode_select == ICC_EVERY) begin
                nxt_st.irq = 1'b1; // see [R6]
            end else if (st_ff.irq_cnt >= irq_lim) begin
                nxt_st.irq_cnt = '0;
                nxt_st.irq = 1'b1; // see [R5]
            end else begin
                nxt_st.irq_cnt = st_ff.irq_cnt + 2'h1;
            end
        end
        if (reg_wr && reg_addr == `ICC_ADDR_CTRL) begin
            nxt_st.idle_halt_select = reg_wdata[`ICC_BIT_IDLE];
            nxt_st.capture_timebase_select =
                icc_tsel_t'(reg_wdata[`ICC_TSEL_HI:`ICC_TSEL_LO]);
            nxt_st.captures_per_irq = reg_wdata[`ICC_CPI_HI:`ICC_CPI_LO];
            nxt_st.capture_mode_select =
                icc_mode_t'(reg_wdata[`ICC_MODE_HI:`ICC_MODE_LO]);
            nxt_st.pre_cnt = '0;
            nxt_st.irq_cnt = '0;
        end
        // overflow clears only when the channel is switched off
        if (st_ff.capture_mode_select == ICC_OFF && !take) begin
            nxt_st.capture_overflow_flag = 1'b0;
        end
        nxt_st.rdata = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `ICC_ADDR_CTRL: nxt_st.rdata = ctrl_rd;
                `ICC_ADDR_BUF: nxt_st.rdata = 16'(fifo_rdata); // see [R15]
                `ICC_ADDR_CNT: nxt_st.rdata = 16'(st_ff.fp_cnt);
                default: nxt_st.rdata = 16'h0000;
            endcase
        end
    end

    always_comb begin
        ctrl_rd = 16'h0000;
        ctrl_rd[`ICC_BIT_IDLE] = st_ff.idle_halt_select;
        ctrl_rd[`ICC_TSEL_HI:`ICC_TSEL_LO] = st_ff.capture_timebase_select;
        ctrl_rd[`ICC_CPI_HI:`ICC_CPI_LO] = st_ff.captures_per_irq;
        ctrl_rd[`ICC_BIT_OV] = st_ff.capture_overflow_flag; // see [R7]
        ctrl_rd[`ICC_BIT_BNE] = fifo_ne; // see [R8]
        ctrl_rd[`ICC_MODE_HI:`ICC_MODE_LO] = st_ff.capture_mode_select;
        ctrl_rd = ctrl_rd & (`ICC_WR_MASK | 16'h0018); // see [R14]
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0; // see [R16]
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign capture_irq = st_ff.irq;
    assign capture_event = st_ff.evt;
endmodule : icc_top

// file: tb/icc_chk_sva.sv
`timescale 1ns/10ps
`include "icc_params.svh"
module icc_chk_sva (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // pin, power and events
    input wire logic capture_channel,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic capture_irq,
    input wire logic capture_event
);
    typedef struct packed {
        logic [2:0] mode;
        logic halt;
        logic [3:0] wcnt;
        logic [3:0] icnt;
    } icc_chk_t;
    icc_chk_t st_ff;
    icc_chk_t nxt_st;
    logic quiet;
    logic run;
    // wait out the pin synchroniser after every control change
    assign quiet = st_ff.wcnt > 4'h5;
    assign run = quiet && !(st_ff.halt && cpu_idle);
    always_comb begin
        nxt_st = st_ff;
        if (st_ff.wcnt != 4'hF) nxt_st.wcnt = st_ff.wcnt + 4'h1;
        if (!cpu_idle) nxt_st.icnt = 4'h0;
        else if (st_ff.icnt != 4'hF) nxt_st.icnt = st_ff.icnt + 4'h1;
        if (reg_wr && reg_addr == `ICC_ADDR_CTRL) begin
            nxt_st.mode = reg_wdata[2:0];
            nxt_st.halt = reg_wdata[`ICC_BIT_IDLE];
            nxt_st.wcnt = 4'h0;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) st_ff <= '0;
        else st_ff <= nxt_st;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
    property p_unimpl;
        $past(reg_rd) && $past(reg_addr) == `ICC_ADDR_CTRL
            |-> (reg_rdata & 16'hC380) == 16'h0000;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented control bits not zero");
    property p_off;
        quiet && st_ff.mode inside {3'h0, 3'h2, 3'h6, 3'h7} |-> !capture_event;
    endproperty
    a_off: assert property (p_off)
        else $error("capture while channel disabled");
    property p_halt;
        quiet && st_ff.halt && st_ff.icnt > 4'h5 |-> !capture_event;
    endproperty
    a_halt: assert property (p_halt)
        else $error("capture while halted in idle");
    property p_fall;
        run && st_ff.mode == 3'h3 && $fell(capture_channel)
            |-> ##[2:5] capture_event;
    endproperty
    a_fall: assert property (p_fall)
        else $error("falling edge not captured");
    property p_rise3;
        run && st_ff.mode == 3'h3 && $rose(capture_channel)
            |-> ##2 !capture_event [*4];
    endproperty
    a_rise3: assert property (p_rise3)
        else $error("rising edge captured in falling mode");
    property p_both;
        run && st_ff.mode == 3'h1 && $changed(capture_channel)
            |-> ##[2:5] capture_event;
    endproperty
    a_both: assert property (p_both)
        else $error("edge not captured in both-edge mode");
    property p_every;
        run && st_ff.mode == 3'h1 && capture_event |-> ##[0:1] capture_irq;
    endproperty
    a_every: assert property (p_every)
        else $error("no interrupt per capture in both-edge mode");
    property p_wake;
        quiet && st_ff.mode == 3'h7 && cpu_sleep && $rose(capture_channel)
            |-> ##[2:5] capture_irq;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake interrupt on rising edge");
    property p_pulse; capture_irq |=> !capture_irq; endproperty
    a_pulse: assert property (p_pulse)
        else $error("interrupt longer than one cycle");
endmodule : icc_chk_sva
bind icc_top icc_chk_sva i_chk (.clk, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .capture_channel, .cpu_idle, .cpu_sleep,
    .capture_irq, .capture_event);

// file: tb/icc_pin_model.sv
`timescale 1ns/10ps
module icc_pin_model (
    // clock
    input wire logic clk,
    // capture pin
    output logic pin
);
    initial pin = 1'b1;
    // levels held long enough to pass the two-flop synchroniser
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            pin <= 1'b0;
            repeat (6) @(posedge clk);
            pin <= 1'b1;
            repeat (5) @(posedge clk);
        end
    endtask : pulse
endmodule : icc_pin_model

// file: tb/tb_top.sv
`timescale 1ns/10ps
`include "icc_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    logic pin;
    logic cpu_idle;
    logic cpu_sleep;
    logic irq;
    logic ev;
    logic was_rd = 1'b0;
    logic [15:0] tv [5];
    logic [16:0] exp_q [$];
    logic [16:0] cur;
    logic [15:0] exp_ctl;
    logic [31:0] lfsr;
    int bad_count, n_checks, n_irq, cyc, base, n_ev, base_ev;
    localparam logic [15:0] t_ctl [12] = '{16'h0023, 16'h0043, 16'h0063,
        16'h0061, 16'h0024, 16'h0005, 16'h0006, 16'h2003, 16'h0003,
        16'h0007, 16'h0000, 16'h0002};
    localparam int t_pul [12] = '{2, 3, 4, 2, 8, 16, 2, 2, 2, 2, 2, 2};
    localparam int t_cap [12] = '{2, 3, 4, 4, 2, 1, 0, 0, 2, 0, 0, 0};
    localparam int t_irq [12] = '{1, 1, 1, 4, 1, 1, 0, 0, 2, 2, 0, 0};
    localparam logic [1:0] t_pwr [12] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h0};
    always #5 clk = ~clk;
    // timer index equals the timebase select code
    icc_top i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .capture_channel(pin), .cpu_idle(cpu_idle),
        .cpu_sleep(cpu_sleep), .timer_one_count(tv[4]),
        .timer_two_count(tv[1]), .timer_three_count(tv[0]),
        .timer_four_count(tv[2]), .timer_five_count(tv[3]),
        .capture_irq(irq), .capture_event(ev));
    icc_pin_model i_pin (.clk(clk), .pin(pin));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back({1'b1, e});
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd
    always @(posedge clk) begin
        if (was_rd) begin
            cur = exp_q.pop_front();
            `CHK("reg_rdata", cur[15:0], reg_rdata)
        end
        if (irq === 1'b1) n_irq++;
        if (ev === 1'b1) n_ev++;
        was_rd <= reg_rd;
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cpu_idle = 1'b0;
        cpu_sleep = 1'b0;
        lfsr = 32'h4E94;
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_next(lfsr);
            tv[i] = lfsr[15:0];
        end
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rd(`ICC_ADDR_CTRL, 16'h0000);
        rd(4'hF, 16'h0000);
        wr(`ICC_ADDR_CTRL, 16'hFFFF);
        rd(`ICC_ADDR_CTRL, `ICC_WR_MASK);
        for (int t = 0; t < 5; t++) begin
            wr(`ICC_ADDR_CTRL, (16'(t) << 10) | 16'h0003);
            repeat (6) @(posedge clk);
            i_pin.pulse(1);
            repeat (4) @(posedge clk);
            rd(`ICC_ADDR_BUF, tv[t]);
            rd(`ICC_ADDR_CTRL, (16'(t) << 10) | 16'h0003);
        end
        for (int k = 0; k < 12; k++) begin
            {cpu_sleep, cpu_idle} <= t_pwr[k];
            wr(`ICC_ADDR_CTRL, t_ctl[k]);
            repeat (6) @(posedge clk);
            base = n_irq;
            base_ev = n_ev;
            i_pin.pulse(t_pul[k]);
            repeat (4) @(posedge clk);
            `CHK("n_irq", t_irq[k], n_irq - base)
            `CHK("n_ev", t_cap[k], n_ev - base_ev)
            exp_ctl = t_ctl[k] | (t_cap[k] > 0 ? 16'h0008 : 16'h0000);
            rd(`ICC_ADDR_CTRL, exp_ctl);
            for (int c = 0; c < t_cap[k]; c++) begin
                rd(`ICC_ADDR_BUF, tv[0]);
            end
            rd(`ICC_ADDR_CTRL, t_ctl[k]);
        end
        // twenty rises at divide-by-4 give five captures into four slots
        wr(`ICC_ADDR_CTRL, 16'h0004);
        repeat (6) @(posedge clk);
        i_pin.pulse(20);
        repeat (4) @(posedge clk);
        rd(`ICC_ADDR_CTRL, 16'h001C);
        rd(`ICC_ADDR_BUF, tv[0]);
        wr(`ICC_ADDR_CTRL, 16'h0000);
        rd(`ICC_ADDR_CTRL, 16'h0000);
        repeat (4) @(posedge clk);
        end_sim();
    end
endmodule : tb_top
